// *** design/bus_error_log_capture.sv ***
// bus error capture with three capture words and a maintenance status word
// assumes bus cycle info arrives synchronous to mclk_in, one cycle_end_in per memory cycle
//
// Overview of operation
// - overwrite capture words each cycle when unlocked
// - freeze capture on error until read
// - status bit 1 shows nvm write ready
// - status bit 4 flags logged error
// - status bits 8-12 give own slot
// - status bit 15 inverted cold start
// - word1 bits 10,9,8 timeout flags
// - word1 bit 11 refresh cycle
// - word1 bits 0-4 address bits 18-22
// - word2 bits 8-12 responder slot
// - word2 bits 0-4 initiator slot
// - word2 bits 5,6,7 scope and record-all
// - word2 bits 15-13 cycle type code
// - no responder captures slot zero
// - word3 bit 15 semaphore, 14 parity check
// - word3 bits 3-9 syndrome
// - word3 bit 11 any fault, 10 multibit
// - word3 bit 1 write, 0 read
// - word3 bits 10-13 classify memory fault
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "fault_capture_map.svh"
module bus_error_log_capture
  import fault_capture_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // memory bus observation
  input  wire logic        cycle_end_in,
  input  wire bus_cycle_s  cycle_in,
  // controller status pins
  input  wire logic        nvm_write_ready_in,
  input  wire logic        warm_start_in,
  input  wire logic [4:0]  own_slot_in,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // error interrupt
  output logic             error_irq_out
);

  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0] nvm_sync_q;
  logic [2:0] warm_sync_q;
  logic       nvm_q;
  logic       warm_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nvm_sync_q  <= 3'h0;
      warm_sync_q <= 3'h0;
      nvm_q       <= 1'b0;
      warm_q      <= 1'b0;
    end else begin
      nvm_sync_q  <= {nvm_sync_q[1:0], nvm_write_ready_in};
      warm_sync_q <= {warm_sync_q[1:0], warm_start_in};
      if (nvm_sync_q[1] == nvm_sync_q[2]) nvm_q <= nvm_sync_q[2];
      if (warm_sync_q[1] == warm_sync_q[2]) warm_q <= warm_sync_q[2];
    end
  end

  // slot number is a strap, caught once after reset release
  logic [4:0] slot_q;
  logic       slot_taken_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_q       <= 5'h00;
      slot_taken_q <= 1'b0;
    end else if (!slot_taken_q) begin
      slot_q       <= own_slot_in;
      slot_taken_q <= 1'b1;
    end
  end

  // packing of the current bus cycle
  wire logic [4:0]  resp_slot = cycle_in.responder_valid ?
                                cycle_in.responder_slot_code : 5'h00;
  wire logic [15:0] word1_now = {4'h0,
                                 cycle_in.refresh_cycle_flag,
                                 cycle_in.addr_ack_timeout,
                                 cycle_in.data_ack_timeout,
                                 cycle_in.data_request_timeout,
                                 3'h0,
                                 cycle_in.captured_addr_high};
  wire logic [15:0] word2_now = {cycle_in.cycle_type_code,
                                 resp_slot,
                                 cycle_in.record_every_fault,
                                 cycle_in.wide_scope_access,
                                 cycle_in.near_scope_access,
                                 cycle_in.initiator_slot_code};
  // any-fault is the or of every bus fault condition
  wire logic        any_fault = cycle_in.addr_ack_timeout | cycle_in.data_ack_timeout |
                                cycle_in.data_request_timeout | cycle_in.multibit_fault |
                                cycle_in.data_fault_type_hi | cycle_in.data_fault_type_lo;
  wire logic [15:0] word3_now = {cycle_in.semaphore_cycle,
                                 cycle_in.write_parity_check,
                                 cycle_in.data_fault_type_hi,
                                 cycle_in.data_fault_type_lo,
                                 any_fault,
                                 cycle_in.multibit_fault,
                                 cycle_in.syndrome_field,
                                 1'b0,
                                 cycle_in.store_direction,
                                 cycle_in.fetch_direction};

  // axi read path
  logic            arready_q;
  logic            rvalid_q;
  logic [31:0]     rdata_q;
  logic [1:0]      rresp_q;
  logic [15:0]     cap1_q;
  logic [15:0]     cap2_q;
  logic [15:0]     cap3_q;
  logic            locked_q;
  logic [31:0]     ctrl_q;
  rd_state_e       rd_state_q;

  wire logic       ar_take   = s_axi_arvalid_in && arready_q;
  wire logic [11:0] ar_ofs   = {s_axi_araddr_in[11:2], 2'b00};
  wire logic [15:0] mstat    = {warm_q, 2'h0, slot_q, 3'h0, locked_q,
                                2'h0, nvm_q, 1'b0};
  wire logic       hit_ms    = (ar_ofs == `OFS_MAINT_STATE);
  wire logic       hit_c1    = (ar_ofs == `OFS_CAP_TIMEOUTS);
  wire logic       hit_c2    = (ar_ofs == `OFS_CAP_PARTIES);
  wire logic       hit_c3    = (ar_ofs == `OFS_CAP_SYNDROME);
  wire logic       hit_ct    = (ar_ofs == `OFS_CTRL);
  wire logic       rd_hit    = hit_ms | hit_c1 | hit_c2 | hit_c3 | hit_ct;
  wire logic [31:0] rd_mux   = hit_ms ? {16'h0000, mstat} :
                               hit_c1 ? {16'h0000, cap1_q} :
                               hit_c2 ? {16'h0000, cap2_q} :
                               hit_c3 ? {16'h0000, cap3_q} :
                               hit_ct ? ctrl_q : 32'h0000_0000;
  // unlock when the syndrome word, the last of the three, is read
  wire logic       unlock    = ar_take && hit_c3;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_state_q <= RD_IDLE;
      arready_q  <= 1'b1;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `AXI_RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (ar_take) begin
            rd_state_q <= RD_RESP;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b1;
            rdata_q    <= rd_mux;
            rresp_q    <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
          end
        end
        RD_RESP: begin
          if (s_axi_rready_in) begin
            rd_state_q <= RD_IDLE;
            arready_q  <= 1'b1;
            rvalid_q   <= 1'b0;
          end
        end
        default: begin
          rd_state_q <= RD_IDLE;
          arready_q  <= 1'b1;
          rvalid_q   <= 1'b0;
        end
      endcase
    end
  end

  // axi write path: address and data in either order
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [11:0] aw_ofs_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  wire logic   aw_take = s_axi_awvalid_in && awready_q;
  wire logic   w_take  = s_axi_wvalid_in && wready_q;
  wire logic   wr_go   = aw_have_q && w_have_q && !bvalid_q;
  wire logic   wr_ctl  = (aw_ofs_q == `OFS_CTRL);
  wire logic [31:0] strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                                 {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_ofs_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `AXI_RESP_OKAY;
      ctrl_q    <= `CTRL_RESET;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        aw_ofs_q  <= {s_axi_awaddr_in[11:2], 2'b00};
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata_in;
        wstrb_q  <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ctl ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        if (wr_ctl) ctrl_q <= (ctrl_q & ~strb_mask) | (wdata_q & strb_mask);
      end
      if (bvalid_q && s_axi_bready_in) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // capture and lock; ctrl bit 0 enables locking, bit 1 also locks on cycles flagged record-all
  wire logic lock_en   = ctrl_q[0];
  wire logic fault_now = cycle_end_in && lock_en &&
                         (any_fault | (ctrl_q[1] & cycle_in.record_every_fault));
  // the read that unlocks also lets the cycle ending on that edge in
  wire logic load      = cycle_end_in && (!locked_q || unlock);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap1_q   <= 16'h0000;
      cap2_q   <= 16'h0000;
      cap3_q   <= 16'h0000;
      locked_q <= 1'b0;
      error_irq_out <= 1'b0;
    end else begin
      if (load) begin
        cap1_q <= word1_now;
        cap2_q <= word2_now;
        cap3_q <= word3_now;
      end
      // a new fault in the unlock cycle locks again: set wins
      if (load && fault_now) begin
        locked_q      <= 1'b1;
        error_irq_out <= 1'b1;
      end else if (unlock) begin
        locked_q      <= 1'b0;
        error_irq_out <= 1'b0;
      end
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out  = wready_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;

  // checks
  sequence s_fault_taken;
    (!locked_q || unlock) && cycle_end_in && fault_now;
  endsequence
  sequence s_open_cycle;
    (!locked_q || unlock) && cycle_end_in;
  endsequence

  chk_fault_locks: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_fault_taken |=> locked_q && error_irq_out)
    else $error("fault did not lock capture");
  chk_frozen_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    locked_q && !unlock |=> $stable(cap1_q) && $stable(cap2_q) && $stable(cap3_q))
    else $error("capture changed while locked");
  chk_open_update: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !locked_q && cycle_end_in |=> cap2_q == $past(word2_now))
    else $error("capture not overwritten");
  chk_irq_logged: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    error_irq_out == mstat[`MS_LOGGED_BIT])
    else $error("irq and logged flag disagree");
  chk_slave_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !locked_q && cycle_end_in && !cycle_in.responder_valid |=> cap2_q[12:8] == 5'h00)
    else $error("missing responder not zero");
  chk_any_or: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cap3_q[`C3_MULTI_BIT] |-> cap3_q[`C3_ANY_BIT])
    else $error("multibit without any fault");
  chk_unlock_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    locked_q && unlock && !(load && fault_now) |=> !locked_q && !error_irq_out)
    else $error("read did not unlock");
  chk_read_answer: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ar_take |=> rvalid_q && rdata_q == $past(rd_mux))
    else $error("read answer wrong");

  // field by field, one cycle after an open bus cycle ends; then lock enable and axi answer hold
  chk_word1_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap1_q == $past(word1_now))
    else $error("capture word 1 not overwritten");
  chk_word3_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap3_q == $past(word3_now))
    else $error("capture word 3 not overwritten");
  chk_timeout_bits: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap1_q[10:8] == $past({cycle_in.addr_ack_timeout,
                                           cycle_in.data_ack_timeout,
                                           cycle_in.data_request_timeout}))
    else $error("timeout bits wrong");
  chk_refresh_bit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap1_q[11] == $past(cycle_in.refresh_cycle_flag))
    else $error("refresh bit wrong");
  chk_addr_bits: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap1_q[4:0] == $past(cycle_in.captured_addr_high))
    else $error("address bits wrong");
  chk_responder_slot: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle ##0 cycle_in.responder_valid |=>
      cap2_q[12:8] == $past(cycle_in.responder_slot_code))
    else $error("responder slot wrong");
  chk_initiator_slot: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap2_q[4:0] == $past(cycle_in.initiator_slot_code))
    else $error("initiator slot wrong");
  chk_scope_bits: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap2_q[7:5] == $past({cycle_in.record_every_fault,
                                          cycle_in.wide_scope_access,
                                          cycle_in.near_scope_access}))
    else $error("scope bits wrong");
  chk_cycle_type: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap2_q[15:13] == $past(cycle_in.cycle_type_code))
    else $error("cycle type wrong");
  chk_sema_parity: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap3_q[15:14] == $past({cycle_in.semaphore_cycle,
                                            cycle_in.write_parity_check}))
    else $error("semaphore or parity bit wrong");
  chk_syndrome_bits: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap3_q[9:3] == $past(cycle_in.syndrome_field))
    else $error("syndrome bits wrong");
  chk_direction_bits: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap3_q[1:0] == $past({cycle_in.store_direction,
                                          cycle_in.fetch_direction}))
    else $error("direction bits wrong");
  chk_fault_class: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap3_q[13:12] == $past({cycle_in.data_fault_type_hi,
                                            cycle_in.data_fault_type_lo}))
    else $error("fault class bits wrong");
  chk_multi_bit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap3_q[10] == $past(cycle_in.multibit_fault))
    else $error("multibit flag wrong");
  chk_unused_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_open_cycle |=> cap1_q[15:12] == 4'h0 && cap1_q[7:5] == 3'h0 && cap3_q[2] == 1'b0)
    else $error("unused capture bits set");
  chk_lock_enable: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !locked_q && !lock_en |=> !locked_q)
    else $error("locked while locking disabled");
  chk_read_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rvalid_q && !s_axi_rready_in |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
    else $error("read answer dropped before taken");
  chk_write_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    bvalid_q && !s_axi_bready_in |=> bvalid_q && $stable(bresp_q))
    else $error("write answer dropped before taken");
endmodule // bus_error_log_capture

// *** design/fault_capture_map.svh ***
// register offsets, field positions and reset values of the fault capture block
// assumes inclusion by the top module and the bench only
`ifndef FAULT_CAPTURE_MAP_SVH
`define FAULT_CAPTURE_MAP_SVH
`define OFS_MAINT_STATE     12'h000
`define OFS_CAP_TIMEOUTS    12'h004
`define OFS_CAP_PARTIES     12'h008
`define OFS_CAP_SYNDROME    12'h00c
`define OFS_CTRL            12'h010
`define CTRL_RESET          32'h0000_0000
`define MS_NVM_READY_BIT    1
`define MS_LOGGED_BIT       4
`define MS_SLOT_LSB         8
`define MS_WARM_BIT         15
`define C1_ADDR_LSB         0
`define C1_DREQ_BIT         8
`define C1_DRDY_BIT         9
`define C1_ARDY_BIT         10
`define C1_REFRESH_BIT      11
`define C2_INIT_LSB         0
`define C2_NEAR_BIT         5
`define C2_WIDE_BIT         6
`define C2_RECALL_BIT       7
`define C2_RESP_LSB         8
`define C2_TYPE_LSB         13
`define C3_FETCH_BIT        0
`define C3_STORE_BIT        1
`define C3_SYN_LSB          3
`define C3_MULTI_BIT        10
`define C3_ANY_BIT          11
`define C3_DLO_BIT          12
`define C3_DHI_BIT          13
`define C3_WPAR_BIT         14
`define C3_SEMA_BIT         15
`define CYC_MEMORY          3'h1
`define CYC_IO              3'h2
`define CYC_BCAST_MEM       3'h5
`define CYC_BCAST_IO        3'h6
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2
`endif

// *** design/fault_capture_pkg.sv ***
// types of the fault capture block
// assumes fault_capture_map.svh for widths of nothing; types only
package fault_capture_pkg;
  typedef struct packed {
    logic       refresh_cycle_flag;
    logic       addr_ack_timeout;
    logic       data_ack_timeout;
    logic       data_request_timeout;
    logic [4:0] captured_addr_high;
    logic [2:0] cycle_type_code;
    logic [4:0] responder_slot_code;
    logic       responder_valid;
    logic       record_every_fault;
    logic       wide_scope_access;
    logic       near_scope_access;
    logic [4:0] initiator_slot_code;
    logic       semaphore_cycle;
    logic       write_parity_check;
    logic       data_fault_type_hi;
    logic       data_fault_type_lo;
    logic       multibit_fault;
    logic [6:0] syndrome_field;
    logic       store_direction;
    logic       fetch_direction;
  } bus_cycle_s;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_e;
endpackage

// *** tb/bus_error_log_capture_bench.sv ***
// self-checking bench for the bus error capture block
// assumes the package and map header are compiled first
`timescale 1ns/10ps
`include "fault_capture_map.svh"
module bus_error_log_capture_bench
  import fault_capture_pkg::*;
;
  logic        mclk_in, rst_n_in, go, cyc_end, nvm, warm;
  logic [4:0]  slot;
  bus_cycle_s  cyc, bus_cyc;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  int          miscompares, n_checks, cyc_cnt;
  logic [39:0] base [4] = '{40'h5a_c3_96_e1_2d, 40'ha5_3c_69_1e_d2,
                            40'hff_ff_ff_ff_ff, 40'h0f_0f_f0_f0_81};
  logic [2:0]  types [4] = '{`CYC_MEMORY, `CYC_IO, `CYC_BCAST_MEM, `CYC_BCAST_IO};

  bus_party_model u_party (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .go_in(go),
    .cyc_in(cyc), .cycle_end_out(cyc_end), .cycle_out(bus_cyc));
  bus_error_log_capture u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .cycle_end_in(cyc_end), .cycle_in(bus_cyc), .nvm_write_ready_in(nvm),
    .warm_start_in(warm), .own_slot_in(slot), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .error_irq_out(irq));

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge mclk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk_in); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // either channel may be taken first
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    @(posedge mclk_in);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    do begin
      @(posedge mclk_in);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    do @(posedge mclk_in); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic send(input bus_cycle_s c);
    @(posedge mclk_in);
    go  <= 1'b1;
    cyc <= c;
    @(posedge mclk_in);
    go <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask

  function automatic logic [47:0] want(input bus_cycle_s c);
    logic any;
    any = c.addr_ack_timeout | c.data_ack_timeout | c.data_request_timeout
        | c.multibit_fault | c.data_fault_type_hi | c.data_fault_type_lo;
    return {4'h0, c.refresh_cycle_flag, c.addr_ack_timeout, c.data_ack_timeout,
            c.data_request_timeout, 3'h0, c.captured_addr_high,
            c.cycle_type_code, c.responder_valid ? c.responder_slot_code : 5'h00,
            c.record_every_fault, c.wide_scope_access, c.near_scope_access,
            c.initiator_slot_code, c.semaphore_cycle, c.write_parity_check,
            c.data_fault_type_hi, c.data_fault_type_lo, any, c.multibit_fault,
            c.syndrome_field, 1'b0, c.store_direction, c.fetch_direction};
  endfunction

  function automatic logic [31:0] stat(input logic logged);
    return {16'h0, warm, 2'h0, slot, 3'h0, logged, 2'h0, nvm, 1'b0};
  endfunction

  // reading word 3 last releases a held capture
  task automatic chk_caps(input bus_cycle_s c);
    logic [31:0] d;
    logic [1:0]  r;
    logic [47:0] w;
    w = want(c);
    rd(`OFS_CAP_TIMEOUTS, d, r);
    check("capture word 1", d, {16'h0, w[47:32]});
    rd(`OFS_CAP_PARTIES, d, r);
    check("capture word 2", d, {16'h0, w[31:16]});
    rd(`OFS_CAP_SYNDROME, d, r);
    check("capture word 3", d, {16'h0, w[15:0]});
  endtask

  initial begin
    cyc_cnt = 0;
    forever begin
      @(posedge mclk_in);
      cyc_cnt++;
      if (cyc_cnt == 4000) begin
        miscompares++;
        close_out();
      end
    end
  end

  initial begin
    bus_cycle_s  c, g;
    logic [31:0] d;
    logic [1:0]  r;
    {go, awvalid, wvalid, bready, arvalid, rready, rst_n_in} = '0;
    {cyc, awaddr, araddr, wdata} = '0;
    nvm  = 1'b1;
    warm = 1'b1;
    slot = 5'h0e;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    check("irq after reset", {31'h0, irq}, 32'h0);
    rd(`OFS_MAINT_STATE, d, r);
    check("status", d, stat(1'b0));
    for (int i = 0; i < 4; i++) begin
      c = bus_cycle_s'(base[i]);
      c.cycle_type_code = types[i];
      c.responder_valid = i[0];
      send(c);
      chk_caps(c);
    end
    // hold a faulty cycle, then offer another that must be ignored
    wr(`OFS_CTRL, 32'h1, r);
    c = bus_cycle_s'(base[0]);
    send(c);
    check("irq on hold", {31'h0, irq}, 32'h1);
    rd(`OFS_MAINT_STATE, d, r);
    check("status logged", d, stat(1'b1));
    send(bus_cycle_s'(base[1]));
    chk_caps(c);
    repeat (2) @(posedge mclk_in);
    check("irq released", {31'h0, irq}, 32'h0);
    g = '0;
    g.record_every_fault = 1'b1;
    g.cycle_type_code = `CYC_MEMORY;
    send(g);
    check("record-all off", {31'h0, irq}, 32'h0);
    wr(`OFS_CTRL, 32'h3, r);
    send(g);
    check("record-all on", {31'h0, irq}, 32'h1);
    chk_caps(g);
    // corrected single-chip fault; syndrome octal 122 points software at one chip
    c = '0;
    c.cycle_type_code     = `CYC_MEMORY;
    c.responder_valid     = 1'b1;
    c.responder_slot_code = 5'h13;
    c.data_fault_type_lo  = 1'b1;
    c.syndrome_field      = 7'h52;
    c.fetch_direction     = 1'b1;
    send(c);
    check("irq corrected", {31'h0, irq}, 32'h1);
    chk_caps(c);
    rd(12'h020, d, r);
    check("unmapped read", {d[29:0], r}, {30'h0, `AXI_RESP_SLVERR});
    wr(`OFS_MAINT_STATE, 32'hffff, r);
    check("status write", {30'h0, r}, {30'h0, `AXI_RESP_SLVERR});
    nvm  <= 1'b0;
    warm <= 1'b0;
    repeat (6) @(posedge mclk_in);
    rd(`OFS_MAINT_STATE, d, r);
    check("status pins", d, stat(1'b0));
    // reset in mid-hold clears interrupt and captures
    send(c);
    rst_n_in <= 1'b0;
    @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    check("irq mid reset", {31'h0, irq}, 32'h0);
    rd(`OFS_CAP_TIMEOUTS, d, r);
    check("capture reset", d, 32'h0);
    close_out();
  end
endmodule // bus_error_log_capture_bench

// *** tb/bus_party_model.sv ***
// far side model: one bus party that finishes a memory cycle on command
// assumes go_in and cyc_in are set by the bench one edge ahead
`timescale 1ns/10ps
module bus_party_model
  import fault_capture_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // bench command
  input  wire logic       go_in,
  input  wire bus_cycle_s cyc_in,
  // bus toward the capture block
  output logic            cycle_end_out,
  output bus_cycle_s      cycle_out
);
  // a released bus toggles so stale values never pass for valid ones
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cycle_end_out <= 1'b0;
      cycle_out     <= '0;
    end else if (go_in) begin
      cycle_end_out <= 1'b1;
      cycle_out     <= cyc_in;
    end else begin
      cycle_end_out <= 1'b0;
      cycle_out     <= ~cycle_out;
    end
  end
endmodule // bus_party_model
